// ===== rtl/vlirq_ctrl.sv
`timescale 1ns/1ps
`include "vlirq_params.svh"
//
// Contract
// [R1] priority level sits in bits 7:5; 0 highest, 7 no priority
// [R2] no suspend: tx dma, rx dma, error, eod/eof, rx full, tx ready
// [R3] suspend on: error above both dma channels, others unchanged
// [R4] writing one to sleep enters sleep; writing zero is ignored
// [R5] sleep, not sending: no rx load, full, overflow, crc, frame, bit, eod
// [R6] sleep while sending: no rx load, full, overflow; errors still set
// [R7] sleep set on reset and tx timeout; held after enable until eof
// [R8] sleep clears on eof or break; forced while disabled
// [R9] rx end-of-block pending sets after last rx dma; irq via rx-full mask
// [R10] tx end-of-block pending sets after last tx dma; irq via tx-ready mask
// [R11] pending flags writable to zero only; zero cancels the request
// [R12] both pending flags clear after disable held six clocks
// [R13] rx end of block clears rx dma mask
// [R14] tx end of block clears tx dma mask
// [R15] mask resets to zero; bit order err,tx_ready_flag,rx_full_flag,tla,rxd,end_data_min,end_frame_min,txd
// [R16] disable held six clocks forces whole mask to zero
// [R17] rx dma mask selects dma or interrupt for rx full
// [R18] tx dma mask selects dma or interrupt for tx ready
// [R19] two-bit source code: error, eod/eof, rx, tx
// [R20] under suspend, dma held off while error or lost-arb flag set
// [R21] only the highest ranked pending request is presented
module vlirq_ctrl (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        PERIPH_ENABLE,
    input  wire logic        PERIPH_DISABLE,
    input  wire logic        TX_ACTIVE,
    input  wire logic        TX_TIMEOUT_FLAG,
    input  wire logic        END_FRAME_RX,
    input  wire logic        BREAK_RX,
    input  wire logic        RX_BYTE_VALID,
    input  wire logic [7:0]  RX_BYTE,
    input  wire logic        RX_OVF_EVT,
    input  wire logic        CRC_ERR_EVT,
    input  wire logic        BAD_FRAME_EVT,
    input  wire logic        BAD_BIT_EVT,
    input  wire logic        END_DATA_EVT,
    input  wire logic        ERROR_FLAG,
    input  wire logic        LOST_ARB_FLAG,
    input  wire logic        END_DATA_MIN,
    input  wire logic        END_FRAME_MIN,
    input  wire logic        RX_FULL_FLAG,
    input  wire logic        TX_READY_FLAG,
    input  wire logic        RX_DMA_EOB,
    input  wire logic        TX_DMA_EOB,
    output logic [2:0]       PRIO_LEVEL,
    output logic             IRQ_REQ,
    output logic             RX_DMA_REQ,
    output logic             TX_DMA_REQ,
    output logic [1:0]       SRC_VECTOR_CODE,
    output logic [7:0]       RX_DATA_REG,
    output logic             RX_DATA_LOAD,
    output logic             RX_FULL_SET,
    output logic             RX_OVF_SET,
    output logic             CRC_ERR_SET,
    output logic             BAD_FRAME_SET,
    output logic             BAD_BIT_SET,
    output logic             END_DATA_SET,
    output logic             RX_SLEEP
);

    vlirq_pkg::vlirq_state_t st_r;
    vlirq_pkg::vlirq_state_t st_nxt;

    logic       setup;
    logic       wr_en;
    logic [7:0] wdat;
    logic       dis_long;
    logic       held_off;
    logic       q_txdma;
    logic       q_rxdma;
    logic       q_err;
    logic       q_eod;
    logic       q_rx;
    logic       q_tx;

    // byte address of a register index
    function automatic logic [11:0] reg_addr(input logic [7:0] idx);
        reg_addr = {2'b00, idx, 2'b00};
    endfunction : reg_addr

    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a == reg_addr(idx));
    endfunction : hit

    always_comb
    begin
        setup    = PSEL & ~PENABLE;
        // write takes effect only at the completing access edge
        wr_en    = PSEL & PENABLE & PWRITE & st_r.pready;
        wdat     = PWDATA[7:0];
        dis_long = (st_r.dis_cnt == `VLIRQ_DIS_CYC);
        // suspend only matters while a fault flag is up
        held_off = st_r.dma_suspend_sel & (ERROR_FLAG | LOST_ARB_FLAG); // [R20]

        q_txdma = TX_READY_FLAG & st_r.irq_mask[`VLIRQ_M_TXD] & ~held_off; // [R18]
        q_rxdma = RX_FULL_FLAG & st_r.irq_mask[`VLIRQ_M_RXD] & ~held_off; // [R17]
        q_err   = (ERROR_FLAG & st_r.irq_mask[`VLIRQ_M_ERR])
                | (LOST_ARB_FLAG & st_r.irq_mask[`VLIRQ_M_TLA]); // [R15]
        q_eod   = (END_DATA_MIN & st_r.irq_mask[`VLIRQ_M_END_DATA_MIN])
                | (END_FRAME_MIN & st_r.irq_mask[`VLIRQ_M_END_FRAME_MIN]);
        q_rx    = st_r.irq_mask[`VLIRQ_M_RX_FULL_FLAG]
                & ((RX_FULL_FLAG & ~st_r.irq_mask[`VLIRQ_M_RXD])
                  | st_r.rx_eob_pending); // [R9] [R17]
        q_tx    = st_r.irq_mask[`VLIRQ_M_TX_READY_FLAG]
                & ((TX_READY_FLAG & ~st_r.irq_mask[`VLIRQ_M_TXD])
                  | st_r.tx_eob_pending); // [R10] [R18]

        st_nxt = st_r;

        // apb slave: one access cycle, reply prepared during setup
        st_nxt.pready  = setup;
        st_nxt.pslverr = 1'b0;
        if (setup)
        begin
            st_nxt.prdata = 8'h00;
            if (hit(PADDR, `VLIRQ_IDX_PRIO))
            begin
                st_nxt.prdata = {st_r.prio_level, st_r.rx_sleep, 2'b00,
                                 st_r.rx_eob_pending, st_r.tx_eob_pending};
            end
            else if (hit(PADDR, `VLIRQ_IDX_MASK))
            begin
                st_nxt.prdata = st_r.irq_mask;
            end
            else if (hit(PADDR, `VLIRQ_IDX_OPT))
            begin
                st_nxt.prdata = {2'b00, st_r.dma_suspend_sel, 5'b0_0000};
            end
            else if (hit(PADDR, `VLIRQ_IDX_STAT))
            begin
                st_nxt.prdata = {3'b000, st_r.tx_dma_req, st_r.rx_dma_req,
                                 st_r.irq_req, st_r.src_vector_code};
            end
            else
            begin
                st_nxt.pslverr = 1'b1;
            end
        end

        if (wr_en && hit(PADDR, `VLIRQ_IDX_PRIO))
        begin
            st_nxt.prio_level = wdat[`VLIRQ_PRL_HI:`VLIRQ_PRL_LO]; // [R1]
            if (wdat[`VLIRQ_SLP_BIT])
            begin
                st_nxt.rx_sleep = 1'b1; // [R4]
            end
            // zero cancels, one is ignored
            if (!wdat[`VLIRQ_REOB_BIT])
            begin
                st_nxt.rx_eob_pending = 1'b0; // [R11]
            end
            if (!wdat[`VLIRQ_TEOB_BIT])
            begin
                st_nxt.tx_eob_pending = 1'b0; // [R11]
            end
        end
        if (wr_en && hit(PADDR, `VLIRQ_IDX_MASK))
        begin
            st_nxt.irq_mask = wdat;
        end
        if (wr_en && hit(PADDR, `VLIRQ_IDX_OPT))
        begin
            st_nxt.dma_suspend_sel = wdat[`VLIRQ_SUSP_BIT];
        end

        // sleep: eof/break clears, later terms win
        if (END_FRAME_RX || BREAK_RX)
        begin
            st_nxt.rx_sleep = 1'b0; // [R8]
        end
        if (TX_TIMEOUT_FLAG)
        begin
            st_nxt.rx_sleep = 1'b1; // [R7]
        end
        if (!PERIPH_ENABLE || PERIPH_DISABLE)
        begin
            st_nxt.rx_sleep = 1'b1; // [R7] [R8]
        end

        // end-of-block: hardware set beats a software clear in the same cycle
        if (RX_DMA_EOB)
        begin
            st_nxt.rx_eob_pending       = 1'b1; // [R9]
            st_nxt.irq_mask[`VLIRQ_M_RXD] = 1'b0; // [R13]
        end
        if (TX_DMA_EOB)
        begin
            st_nxt.tx_eob_pending       = 1'b1; // [R10]
            st_nxt.irq_mask[`VLIRQ_M_TXD] = 1'b0; // [R14]
        end

        // disable filter: a short pulse leaves masks and pending flags alone
        if (!PERIPH_DISABLE)
        begin
            st_nxt.dis_cnt = 3'h0;
        end
        else if (!dis_long)
        begin
            st_nxt.dis_cnt = st_r.dis_cnt + 3'h1;
        end
        if (dis_long)
        begin
            st_nxt.irq_mask       = `VLIRQ_MASK_RST; // [R16]
            st_nxt.rx_eob_pending = 1'b0; // [R12]
            st_nxt.tx_eob_pending = 1'b0; // [R12]
        end

        // arbitration; level 7 means the peripheral never wins
        st_nxt.irq_req    = 1'b0;
        st_nxt.rx_dma_req = 1'b0;
        st_nxt.tx_dma_req = 1'b0;
        if (st_r.prio_level != `VLIRQ_PRL_NONE) // [R1]
        begin
            if (st_r.dma_suspend_sel && q_err)
            begin
                st_nxt.irq_req         = 1'b1; // [R3]
                st_nxt.src_vector_code = vlirq_pkg::VLIRQ_V_ERR;
            end
            else if (q_txdma)
            begin
                st_nxt.tx_dma_req = 1'b1; // [R2] [R21]
            end
            else if (q_rxdma)
            begin
                st_nxt.rx_dma_req = 1'b1; // [R2] [R21]
            end
            else if (q_err)
            begin
                st_nxt.irq_req         = 1'b1; // [R2]
                st_nxt.src_vector_code = vlirq_pkg::VLIRQ_V_ERR; // [R19]
            end
            else if (q_eod)
            begin
                st_nxt.irq_req         = 1'b1; // [R2]
                st_nxt.src_vector_code = vlirq_pkg::VLIRQ_V_EOD; // [R19]
            end
            else if (q_rx)
            begin
                st_nxt.irq_req         = 1'b1; // [R2]
                st_nxt.src_vector_code = vlirq_pkg::VLIRQ_V_RX; // [R19]
            end
            else if (q_tx)
            begin
                st_nxt.irq_req         = 1'b1; // [R2]
                st_nxt.src_vector_code = vlirq_pkg::VLIRQ_V_TX; // [R19]
            end
        end

        // receive gating; errors still pass while sending in sleep
        st_nxt.rx_load       = RX_BYTE_VALID & ~st_r.rx_sleep; // [R5] [R6]
        st_nxt.rx_full_set   = RX_BYTE_VALID & ~st_r.rx_sleep; // [R5] [R6]
        st_nxt.rx_ovf_set    = RX_OVF_EVT & ~st_r.rx_sleep; // [R5] [R6]
        st_nxt.crc_err_set   = CRC_ERR_EVT & (~st_r.rx_sleep | TX_ACTIVE); // [R6]
        st_nxt.bad_frame_set = BAD_FRAME_EVT & (~st_r.rx_sleep | TX_ACTIVE); // [R6]
        st_nxt.bad_bit_set   = BAD_BIT_EVT & (~st_r.rx_sleep | TX_ACTIVE); // [R6]
        st_nxt.end_data_set  = END_DATA_EVT & (~st_r.rx_sleep | TX_ACTIVE); // [R5]
        if (RX_BYTE_VALID && !st_r.rx_sleep)
        begin
            st_nxt.rx_data_reg = RX_BYTE; // [R5]
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st_r                 <= '0;
            st_r.prio_level      <= 3'(`VLIRQ_PRIO_RST >> `VLIRQ_PRL_LO);
            st_r.rx_sleep        <= 1'b1; // [R7]
            st_r.irq_mask        <= `VLIRQ_MASK_RST; // [R15]
            st_r.dma_suspend_sel <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign PRDATA          = {24'h00_0000, st_r.prdata};
    assign PREADY          = st_r.pready;
    // error flop only rises in the reply cycle, so it already stands with ready
    assign PSLVERR         = st_r.pslverr;
    assign PRIO_LEVEL      = st_r.prio_level;
    assign IRQ_REQ         = st_r.irq_req;
    assign RX_DMA_REQ      = st_r.rx_dma_req;
    assign TX_DMA_REQ      = st_r.tx_dma_req;
    assign SRC_VECTOR_CODE = st_r.src_vector_code;
    assign RX_DATA_REG     = st_r.rx_data_reg;
    assign RX_DATA_LOAD    = st_r.rx_load;
    assign RX_FULL_SET     = st_r.rx_full_set;
    assign RX_OVF_SET      = st_r.rx_ovf_set;
    assign CRC_ERR_SET     = st_r.crc_err_set;
    assign BAD_FRAME_SET   = st_r.bad_frame_set;
    assign BAD_BIT_SET     = st_r.bad_bit_set;
    assign END_DATA_SET    = st_r.end_data_set;
    assign RX_SLEEP        = st_r.rx_sleep;

endmodule : vlirq_ctrl

// ===== rtl/vlirq_params.svh
`ifndef VLIRQ_PARAMS_SVH
`define VLIRQ_PARAMS_SVH
// register indices; byte address is four times the index
`define VLIRQ_IDX_PRIO   8'hF9
`define VLIRQ_IDX_MASK   8'hFA
`define VLIRQ_IDX_OPT    8'hFB
`define VLIRQ_IDX_STAT   8'hFC
`define VLIRQ_PRIO_RST   8'h10
`define VLIRQ_MASK_RST   8'h00
`define VLIRQ_OPT_RST    8'h00
// priority register fields
`define VLIRQ_PRL_HI     7
`define VLIRQ_PRL_LO     5
`define VLIRQ_SLP_BIT    4
`define VLIRQ_REOB_BIT   1
`define VLIRQ_TEOB_BIT   0
`define VLIRQ_PRL_NONE   3'h7
// mask register fields
`define VLIRQ_M_ERR      7
`define VLIRQ_M_TX_READY_FLAG     6
`define VLIRQ_M_RX_FULL_FLAG     5
`define VLIRQ_M_TLA      4
`define VLIRQ_M_RXD      3
`define VLIRQ_M_END_DATA_MIN     2
`define VLIRQ_M_END_FRAME_MIN     1
`define VLIRQ_M_TXD      0
// option register field
`define VLIRQ_SUSP_BIT   5
// disable must stand this many clocks before masks and pending flags clear
`define VLIRQ_DIS_CYC    3'h6
`endif

// ===== rtl/vlirq_pkg.sv
package vlirq_pkg;
    // source group code reported to the vector register
    typedef enum logic [1:0] {
        VLIRQ_V_ERR = 2'b00,
        VLIRQ_V_EOD = 2'b01,
        VLIRQ_V_RX  = 2'b10,
        VLIRQ_V_TX  = 2'b11
    } vlirq_vec_t;

    typedef struct packed {
        logic [2:0]  prio_level;
        logic        rx_sleep;
        logic        rx_eob_pending;
        logic        tx_eob_pending;
        logic [7:0]  irq_mask;
        logic        dma_suspend_sel;
        logic [2:0]  dis_cnt;
        logic        pready;
        logic        pslverr;
        logic [7:0]  prdata;
        logic        irq_req;
        logic        rx_dma_req;
        logic        tx_dma_req;
        vlirq_vec_t  src_vector_code;
        logic [7:0]  rx_data_reg;
        logic        rx_load;
        logic        rx_full_set;
        logic        rx_ovf_set;
        logic        crc_err_set;
        logic        bad_frame_set;
        logic        bad_bit_set;
        logic        end_data_set;
    } vlirq_state_t;
endpackage : vlirq_pkg

// ===== tb/vlirq_ctrl_properties.sv
`timescale 1ns/1ps
module vlirq_chk (
    input wire logic       CLK_SYS,
    input wire logic       RST_N,
    input wire logic       PERIPH_ENABLE,
    input wire logic       PERIPH_DISABLE,
    input wire logic       TX_ACTIVE,
    input wire logic       TX_TIMEOUT_FLAG,
    input wire logic       RX_BYTE_VALID,
    input wire logic [7:0] RX_BYTE,
    input wire logic       CRC_ERR_EVT,
    input wire logic [2:0] PRIO_LEVEL,
    input wire logic       IRQ_REQ,
    input wire logic       RX_DMA_REQ,
    input wire logic       TX_DMA_REQ,
    input wire logic [7:0] RX_DATA_REG,
    input wire logic       RX_DATA_LOAD,
    input wire logic       RX_FULL_SET,
    input wire logic       RX_OVF_SET,
    input wire logic       CRC_ERR_SET,
    input wire logic       END_DATA_SET,
    input wire logic       RX_SLEEP
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    wire logic quiet = !IRQ_REQ && !RX_DMA_REQ && !TX_DMA_REQ;
    wire logic rx_in = RX_DATA_LOAD || RX_FULL_SET || RX_OVF_SET;
    wire logic live  = PERIPH_ENABLE && !PERIPH_DISABLE;
    // eight edges: six to count, one to clear the masks, one for the request
    sequence dis_held; PERIPH_DISABLE [*8]; endsequence
    sequence asleep_rx; RX_SLEEP && !TX_ACTIVE; endsequence
    sequence asleep_tx; RX_SLEEP && TX_ACTIVE; endsequence
    one_req_a: assert property ($onehot0({IRQ_REQ, RX_DMA_REQ, TX_DMA_REQ}))
        else $error("two requests at once");
    no_prio_a: assert property (PRIO_LEVEL == 3'h7 |=> quiet)
        else $error("request at level seven");
    dis_clear_a: assert property (dis_held |=> quiet)
        else $error("request after long disable");
    dis_sleep_a: assert property (PERIPH_DISABLE || !PERIPH_ENABLE |=> RX_SLEEP)
        else $error("awake while disabled");
    tto_sleep_a: assert property (TX_TIMEOUT_FLAG |=> RX_SLEEP)
        else $error("awake after timeout");
    quiet_rx_a: assert property (asleep_rx |=> !rx_in && !CRC_ERR_SET && !END_DATA_SET)
        else $error("receive flag while asleep");
    tx_sleep_a: assert property (asleep_tx |=> !rx_in)
        else $error("receive data while asleep");
    crc_pass_a: assert property (asleep_tx ##0 CRC_ERR_EVT |=> CRC_ERR_SET)
        else $error("crc error lost while sending");
    rx_load_a: assert property (live && !RX_SLEEP && RX_BYTE_VALID |=>
        RX_DATA_LOAD && RX_DATA_REG == $past(RX_BYTE)) else $error("byte not loaded");
endmodule : vlirq_chk
bind vlirq_ctrl vlirq_chk chk_u (.CLK_SYS, .RST_N, .PERIPH_ENABLE, .PERIPH_DISABLE,
    .TX_ACTIVE, .TX_TIMEOUT_FLAG, .RX_BYTE_VALID, .RX_BYTE, .CRC_ERR_EVT, .PRIO_LEVEL,
    .IRQ_REQ, .RX_DMA_REQ, .TX_DMA_REQ, .RX_DATA_REG, .RX_DATA_LOAD, .RX_FULL_SET,
    .RX_OVF_SET, .CRC_ERR_SET, .END_DATA_SET, .RX_SLEEP);

// ===== tb/vlirq_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "vlirq_params.svh"
module vlirq_ctrl_tb_top;
    localparam logic [11:0] A_PRIO = {2'h0, `VLIRQ_IDX_PRIO, 2'h0};
    localparam logic [11:0] A_MASK = {2'h0, `VLIRQ_IDX_MASK, 2'h0};
    localparam logic [11:0] A_OPT  = {2'h0, `VLIRQ_IDX_OPT, 2'h0};
    localparam logic [11:0] A_STAT = {2'h0, `VLIRQ_IDX_STAT, 2'h0};
    logic        CLK_SYS, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ_REQ, RX_SLEEP;
    logic        PERIPH_ENABLE, PERIPH_DISABLE, TX_ACTIVE, TX_TIMEOUT_FLAG, END_FRAME_RX;
    logic        RX_BYTE_VALID, CRC_ERR_EVT, END_DATA_EVT, ERROR_FLAG, LOST_ARB_FLAG;
    logic        END_DATA_MIN, RX_FULL_FLAG, TX_READY_FLAG, RX_DMA_EOB, TX_DMA_EOB;
    logic        RX_DMA_REQ, TX_DMA_REQ, RX_DATA_LOAD, RX_FULL_SET, RX_OVF_SET;
    logic        CRC_ERR_SET, END_DATA_SET, BAD_FRAME_SET, BAD_BIT_SET;
    logic        BREAK_RX, END_FRAME_MIN, RX_OVF_EVT, BAD_FRAME_EVT, BAD_BIT_EVT;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic [7:0]  RX_BYTE, RX_DATA_REG, seen;
    logic [2:0]  PRIO_LEVEL;
    logic [1:0]  SRC_VECTOR_CODE;
    int          failures, n_checks;
    vlirq_ctrl dut_u (.CLK_SYS, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .PERIPH_ENABLE, .PERIPH_DISABLE, .TX_ACTIVE, .TX_TIMEOUT_FLAG,
        .END_FRAME_RX, .BREAK_RX, .RX_BYTE_VALID, .RX_BYTE, .RX_OVF_EVT,
        .CRC_ERR_EVT, .BAD_FRAME_EVT, .BAD_BIT_EVT, .END_DATA_EVT, .ERROR_FLAG,
        .LOST_ARB_FLAG, .END_DATA_MIN, .END_FRAME_MIN, .RX_FULL_FLAG, .TX_READY_FLAG,
        .RX_DMA_EOB, .TX_DMA_EOB, .PRIO_LEVEL, .IRQ_REQ, .RX_DMA_REQ, .TX_DMA_REQ,
        .SRC_VECTOR_CODE, .RX_DATA_REG, .RX_DATA_LOAD, .RX_FULL_SET, .RX_OVF_SET,
        .CRC_ERR_SET, .BAD_FRAME_SET, .BAD_BIT_SET, .END_DATA_SET, .RX_SLEEP);
    vlirq_mcu_model mcu_u (.CLK_SYS, .RST_N, .IRQ_REQ, .RX_DMA_REQ, .TX_DMA_REQ,
        .SRC_VECTOR_CODE, .seen);
    always #5 CLK_SYS = ~CLK_SYS;
    task close_out;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task cyc(input int k);
        repeat (k) @(posedge CLK_SYS);
    endtask : cyc
    // e holds {error response, read byte}
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [8:0] e);
        int n;
        n = 0;
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= {24'h00_0000, d};
        cyc(1);
        PENABLE <= 1'h1;
        do
        begin
            cyc(1);
            n++;
        end
        while (PREADY !== 1'h1 && n < 16);
        if (PREADY !== 1'h1)
        begin
            failures++;
            close_out();
        end
        if (!w)
            chk(PRDATA[7:0], e[7:0]);
        chk({7'h00, PSLVERR}, {7'h00, e[8]});
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        cyc(1);
    endtask : apb
    task ev(input logic [4:0] m);
        {BREAK_RX, END_FRAME_RX, TX_TIMEOUT_FLAG, RX_DMA_EOB, TX_DMA_EOB} <= m;
        cyc(1);
        {BREAK_RX, END_FRAME_RX, TX_TIMEOUT_FLAG, RX_DMA_EOB, TX_DMA_EOB} <= 5'h00;
        cyc(1);
    endtask : ev
    // three edges: design register, then the model's snapshot
    task see(input logic [7:0] e);
        cyc(3);
        chk(seen, e);
    endtask : see
    initial
    begin
        {CLK_SYS, RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, PERIPH_ENABLE, PERIPH_DISABLE,
         TX_ACTIVE, TX_TIMEOUT_FLAG, END_FRAME_RX, RX_BYTE_VALID, RX_BYTE, CRC_ERR_EVT,
         END_DATA_EVT, ERROR_FLAG, LOST_ARB_FLAG, END_DATA_MIN, RX_FULL_FLAG, TX_READY_FLAG,
         RX_DMA_EOB, TX_DMA_EOB, BREAK_RX, END_FRAME_MIN, RX_OVF_EVT, BAD_FRAME_EVT,
         BAD_BIT_EVT} = '0;
        failures = 0;
        n_checks = 0;
        cyc(3);
        RST_N <= 1'h1;
        cyc(1);
        apb(1'h0, A_PRIO, 8'h00, 9'h010);
        apb(1'h0, A_MASK, 8'h00, 9'h000);
        apb(1'h0, 12'h000, 8'h00, 9'h100);
        apb(1'h1, A_PRIO, 8'h00, 9'h000);
        apb(1'h0, A_PRIO, 8'h00, 9'h010);
        PERIPH_ENABLE <= 1'h1;
        cyc(2);
        chk({7'h00, RX_SLEEP}, 8'h01);
        ev(5'h08);
        chk({7'h00, RX_SLEEP}, 8'h00);
        RX_BYTE <= 8'hA5;
        RX_BYTE_VALID <= 1'h1;
        cyc(1);
        RX_BYTE_VALID <= 1'h0;
        cyc(2);
        chk(RX_DATA_REG, 8'hA5);
        ev(5'h04);
        chk({7'h00, RX_SLEEP}, 8'h01);
        ev(5'h10);
        chk({7'h00, RX_SLEEP}, 8'h00);
        apb(1'h1, A_PRIO, 8'h10, 9'h000);
        apb(1'h0, A_PRIO, 8'h00, 9'h010);
        // asleep: an idle receiver drops all, a sending one keeps the errors
        for (int t = 0; t < 2; t++)
        begin
            TX_ACTIVE <= 1'(t);
            {RX_BYTE_VALID, RX_OVF_EVT, CRC_ERR_EVT,
             BAD_FRAME_EVT, BAD_BIT_EVT, END_DATA_EVT} <= 6'h3F;
            cyc(1);
            {RX_BYTE_VALID, RX_OVF_EVT, CRC_ERR_EVT,
             BAD_FRAME_EVT, BAD_BIT_EVT, END_DATA_EVT} <= 6'h00;
            cyc(1);
            chk({1'h0, RX_DATA_LOAD, RX_FULL_SET, RX_OVF_SET, CRC_ERR_SET, BAD_FRAME_SET,
                 BAD_BIT_SET, END_DATA_SET}, t ? 8'h0F : 8'h00);
        end
        TX_ACTIVE <= 1'h0;
        apb(1'h1, A_MASK, 8'hF6, 9'h000);
        for (int i = 0; i < 4; i++)
        begin
            {ERROR_FLAG, END_DATA_MIN, RX_FULL_FLAG, TX_READY_FLAG} <= 4'hF >> i;
            see(8'h04 + 8'(i));
            apb(1'h0, A_STAT, 8'h00, {1'h0, 8'h04 + 8'(i)});
        end
        END_FRAME_MIN <= 1'h1;
        see(8'h05);
        END_FRAME_MIN <= 1'h0;
        apb(1'h1, A_MASK, 8'hFF, 9'h000);
        {ERROR_FLAG, END_DATA_MIN, RX_FULL_FLAG, TX_READY_FLAG} <= 4'hF;
        see(8'h10);
        TX_READY_FLAG <= 1'h0;
        see(8'h08);
        apb(1'h1, A_OPT, 8'h20, 9'h000);
        apb(1'h0, A_OPT, 8'h00, 9'h020);
        see(8'h04);
        {ERROR_FLAG, LOST_ARB_FLAG, TX_READY_FLAG} <= 3'h3;
        see(8'h04);
        LOST_ARB_FLAG <= 1'h0;
        see(8'h10);
        apb(1'h1, A_OPT, 8'h00, 9'h000);
        apb(1'h1, A_PRIO, 8'hE0, 9'h000);
        see(8'h00);
        {ERROR_FLAG, END_DATA_MIN, RX_FULL_FLAG, TX_READY_FLAG} <= 4'h0;
        apb(1'h1, A_PRIO, 8'h00, 9'h000);
        for (int i = 0; i < 2; i++)
        begin
            apb(1'h1, A_MASK, i ? 8'h41 : 8'h28, 9'h000);
            ev(i ? 5'h01 : 5'h02);
            see(i ? 8'h07 : 8'h06);
            apb(1'h0, A_MASK, 8'h00, i ? 9'h040 : 9'h020);
            apb(1'h0, A_PRIO, 8'h00, i ? 9'h011 : 9'h012);
            apb(1'h1, A_PRIO, 8'h13, 9'h000);
            apb(1'h0, A_PRIO, 8'h00, i ? 9'h011 : 9'h012);
            apb(1'h1, A_PRIO, 8'h00, 9'h000);
            see(8'h00);
        end
        apb(1'h1, A_MASK, 8'hF6, 9'h000);
        ev(5'h03);
        PERIPH_DISABLE <= 1'h1;
        cyc(8);
        PERIPH_DISABLE <= 1'h0;
        apb(1'h0, A_MASK, 8'h00, 9'h000);
        apb(1'h0, A_PRIO, 8'h00, 9'h010);
        close_out();
    end
endmodule : vlirq_ctrl_tb_top

// ===== tb/vlirq_mcu_model.sv
`timescale 1ns/1ps
module vlirq_mcu_model (
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    input  wire logic       IRQ_REQ,
    input  wire logic       RX_DMA_REQ,
    input  wire logic       TX_DMA_REQ,
    input  wire logic [1:0] SRC_VECTOR_CODE,
    output logic      [7:0] seen
);
    // vector fetched only under a request; a stale code is never read
    always_ff @(posedge CLK_SYS or negedge RST_N)
        if (!RST_N)
            seen <= 8'h00;
        else
            seen <= {3'h0, TX_DMA_REQ, RX_DMA_REQ, IRQ_REQ, IRQ_REQ ? SRC_VECTOR_CODE : 2'h0};
endmodule : vlirq_mcu_model
